// >>> iwb_defines.vh
// Purpose: Shared constants of the host-side command interface of the wire bridge.
// Assumes: Included by bare name from every design file of the bridge.
// Notes:   Codes are byte values seen on the host bus.
`ifndef IWB_DEFINES_VH
`define IWB_DEFINES_VH

// Command codes.
`define IWB_CMD_CHIP_RESET   8'hF0
`define IWB_CMD_CONFIG_WR    8'hD2
`define IWB_CMD_PTR_SELECT   8'hE1
`define IWB_CMD_LINE_RESET   8'hB4
`define IWB_CMD_BYTE_WRITE   8'hA5
`define IWB_CMD_BYTE_READ    8'h96

// Read pointer codes.
`define IWB_PTR_STATUS       8'hF0
`define IWB_PTR_RX_BYTE      8'hE1
`define IWB_PTR_LINE_SETUP   8'hC3

// Status byte layout and reset values.
`define IWB_ST_BUSY_BIT      0
`define IWB_ST_PRESENCE_BIT  1
`define IWB_SETUP_RESET      8'h00
`define IWB_BYTE_ZERO        8'h00

// Default host bus address and bit counts.
`define IWB_HOST_ADDR        7'h18
`define IWB_BITS_PER_BYTE    4'h8
`define IWB_LAST_TX_BIT      4'h7
`define IWB_BIT_ZERO         4'h0
`define IWB_BIT_ONE          4'h1

`endif

// >>> iwb_cmd_buffer.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Output side is registered; in_ready_o is low only when both entries hold data.
`include "iwb_defines.vh"
`default_nettype none

module iwb_cmd_buffer #(
   parameter WIDTH = 16
) (
   input  wire             ref_clk_i,
   input  wire             rst_i,
   input  wire             in_valid_i,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             in_ready_o,
   output reg              out_valid_o,
   output reg  [WIDTH-1:0] out_data_o,
   input  wire             out_ready_i
);

   reg             spare_valid_r;
   reg [WIDTH-1:0] spare_data_r;
   wire            take_in;
   wire            take_out;

   assign in_ready_o = ~spare_valid_r;
   assign take_in    = in_valid_i & ~spare_valid_r;
   assign take_out   = out_valid_o & out_ready_i;

   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         out_valid_o   <= 1'b0;
         out_data_o    <= {WIDTH{1'b0}};
         spare_valid_r <= 1'b0;
         spare_data_r  <= {WIDTH{1'b0}};
      end
      else
      begin
         if (!out_valid_o || take_out)
         begin
            if (spare_valid_r)
            begin
               out_valid_o   <= 1'b1;
               out_data_o    <= spare_data_r;
               spare_valid_r <= take_in;
               spare_data_r  <= in_data_i;
            end
            else
            begin
               out_valid_o <= take_in;
               out_data_o  <= in_data_i;
            end
         end
         else if (take_in)
         begin
            spare_valid_r <= 1'b1;
            spare_data_r  <= in_data_i;
         end
      end
   end

endmodule // iwb_cmd_buffer

`default_nettype wire

// >>> iwb_host_cmd.v
// Purpose: Host bus slave that takes commands for the wire engine and serves its registers.
// Assumes: scl_i and sda_i are synchronous to ref_clk_i; the wire engine sits outside.
// Notes:   sda is open drain: sda_oe_o high pulls the line low.
//
// How it works
// - Refuse config, line reset, byte write while busy.
// - Pointer code C3h selects line setup register.
// - Invalid pointer code refused, pointer kept.
// - Each status read byte is freshly sampled.
// - Byte write takes one data byte, sent out.
// - Busy set during wire work, cleared after.
// - Pointer E1h returns byte received from wire.
// - Pointer select accepted while wire busy.
// - Extra bytes and bad parameters never acknowledged.
// - Decode the six command codes.
// - Every read byte comes from pointed register.
`include "iwb_defines.vh"
`default_nettype none

module iwb_host_cmd #(
   parameter [6:0] HOST_ADDR = `IWB_HOST_ADDR
) (
   input  wire       ref_clk_i,
   input  wire       rst_i,
   input  wire       scl_i,
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe_o,
   output wire       cmd_valid_o,
   output wire [7:0] cmd_code_o,
   output wire [7:0] cmd_data_o,
   input  wire       cmd_ready_i,
   input  wire       wire_done_i,
   input  wire [7:0] wire_rx_byte_i,
   input  wire       wire_presence_i,
   output reg  [7:0] line_setup_o,
   output reg        chip_reset_o,
   output reg        wire_busy_flag_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus states and storage.

   localparam [5:0] ST_IDLE = 6'b000001;
   localparam [5:0] ST_RX   = 6'b000010;
   localparam [5:0] ST_ACK  = 6'b000100;
   localparam [5:0] ST_TX   = 6'b001000;
   localparam [5:0] ST_MACK = 6'b010000;
   localparam [5:0] ST_IGN  = 6'b100000;

   reg  [5:0] state_r;
   reg        scl_q_r;
   reg        sda_q_r;
   reg  [3:0] bit_cnt_r;
   reg  [7:0] shift_r;
   reg        addr_phase_r;
   reg        rd_mode_r;
   reg        param_phase_r;
   reg        extra_r;
   reg  [7:0] cmd_r;
   reg        ack_r;
   reg  [7:0] read_ptr_r;
   reg  [7:0] rx_byte_r;
   reg        presence_r;
   reg  [7:0] last_cmd_r;
   reg        push_r;
   reg  [7:0] push_code_r;
   reg  [7:0] push_data_r;
   reg  [7:0] read_byte;
   wire       in_ready;
   wire       scl_rise;
   wire       scl_fall;
   wire       bus_start;
   wire       bus_stop;
   wire       busy;

   assign scl_rise  = scl_i & ~scl_q_r;
   assign scl_fall  = ~scl_i & scl_q_r;
   assign bus_start = scl_i & scl_q_r & sda_q_r & ~sda_i;
   assign bus_stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;
   // A full buffer counts as busy so that no command is pushed into it.
   assign busy      = wire_busy_flag_o | ~in_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Register read selection.

   always @*
   begin
      case (read_ptr_r)
         `IWB_PTR_RX_BYTE:    read_byte = rx_byte_r;
         `IWB_PTR_LINE_SETUP: read_byte = line_setup_o;
         default:
         begin
            read_byte = `IWB_BYTE_ZERO;
            read_byte[`IWB_ST_BUSY_BIT]     = wire_busy_flag_o;
            read_byte[`IWB_ST_PRESENCE_BIT] = presence_r;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host bus byte engine and command decode.

   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_r       <= ST_IDLE;
         scl_q_r       <= 1'b1;
         sda_q_r       <= 1'b1;
         bit_cnt_r     <= `IWB_BIT_ZERO;
         shift_r       <= `IWB_BYTE_ZERO;
         addr_phase_r  <= 1'b0;
         rd_mode_r     <= 1'b0;
         param_phase_r <= 1'b0;
         extra_r       <= 1'b0;
         cmd_r         <= `IWB_BYTE_ZERO;
         ack_r         <= 1'b0;
         read_ptr_r    <= `IWB_PTR_STATUS;
         line_setup_o  <= `IWB_SETUP_RESET;
         chip_reset_o  <= 1'b0;
         push_r        <= 1'b0;
         push_code_r   <= `IWB_BYTE_ZERO;
         push_data_r   <= `IWB_BYTE_ZERO;
         sda_o         <= 1'b0;
         sda_oe_o      <= 1'b0;
      end
      else
      begin
         scl_q_r      <= scl_i;
         sda_q_r      <= sda_i;
         push_r       <= 1'b0;
         chip_reset_o <= 1'b0;
         sda_o        <= 1'b0;
         if (bus_start)
         begin
            state_r      <= ST_RX;
            addr_phase_r <= 1'b1;
            bit_cnt_r    <= `IWB_BIT_ZERO;
            sda_oe_o     <= 1'b0;
         end
         else if (bus_stop)
         begin
            state_r  <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end
         else
         begin
            case (state_r)
               ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shift_r   <= {shift_r[6:0], sda_i};
                     bit_cnt_r <= bit_cnt_r + `IWB_BIT_ONE;
                  end
                  else if (scl_fall && bit_cnt_r == `IWB_BITS_PER_BYTE)
                  begin
                     state_r <= ST_ACK;
                     ack_r   <= 1'b0;
                     if (addr_phase_r)
                     begin
                        if (shift_r[7:1] == HOST_ADDR)
                        begin
                           ack_r         <= 1'b1;
                           sda_oe_o      <= 1'b1;
                           rd_mode_r     <= shift_r[0];
                           param_phase_r <= 1'b0;
                           extra_r       <= 1'b0;
                        end
                     end
                     else if (extra_r)
                     begin
                        // The command is complete, so any further byte is refused.
                        ack_r <= 1'b0;
                     end
                     else if (!param_phase_r)
                     begin
                        cmd_r <= shift_r;
                        case (shift_r)
                           `IWB_CMD_CHIP_RESET:
                           begin
                              ack_r        <= 1'b1;
                              sda_oe_o     <= 1'b1;
                              chip_reset_o <= 1'b1;
                              read_ptr_r   <= `IWB_PTR_STATUS;
                              line_setup_o <= `IWB_SETUP_RESET;
                              extra_r      <= 1'b1;
                           end
                           `IWB_CMD_PTR_SELECT:
                           begin
                              ack_r         <= 1'b1;
                              sda_oe_o      <= 1'b1;
                              param_phase_r <= 1'b1;
                           end
                           `IWB_CMD_CONFIG_WR, `IWB_CMD_BYTE_WRITE:
                           begin
                              if (!busy)
                              begin
                                 ack_r         <= 1'b1;
                                 sda_oe_o      <= 1'b1;
                                 param_phase_r <= 1'b1;
                              end
                           end
                           `IWB_CMD_LINE_RESET, `IWB_CMD_BYTE_READ:
                           begin
                              if (!busy)
                              begin
                                 ack_r       <= 1'b1;
                                 sda_oe_o    <= 1'b1;
                                 push_r      <= 1'b1;
                                 push_code_r <= shift_r;
                                 push_data_r <= `IWB_BYTE_ZERO;
                                 extra_r     <= 1'b1;
                              end
                           end
                           default:
                           begin
                              ack_r <= 1'b0;
                           end
                        endcase
                     end
                     else
                     begin
                        // Only one parameter byte is ever expected.
                        param_phase_r <= 1'b0;
                        extra_r       <= 1'b1;
                        case (cmd_r)
                           `IWB_CMD_PTR_SELECT:
                           begin
                              if (shift_r == `IWB_PTR_STATUS ||
                                  shift_r == `IWB_PTR_RX_BYTE ||
                                  shift_r == `IWB_PTR_LINE_SETUP)
                              begin
                                 ack_r      <= 1'b1;
                                 sda_oe_o   <= 1'b1;
                                 read_ptr_r <= shift_r;
                              end
                           end
                           `IWB_CMD_CONFIG_WR:
                           begin
                              ack_r        <= 1'b1;
                              sda_oe_o     <= 1'b1;
                              line_setup_o <= shift_r;
                           end
                           `IWB_CMD_BYTE_WRITE:
                           begin
                              ack_r       <= 1'b1;
                              sda_oe_o    <= 1'b1;
                              push_r      <= 1'b1;
                              push_code_r <= cmd_r;
                              push_data_r <= shift_r;
                           end
                           default:
                           begin
                              ack_r <= 1'b0;
                           end
                        endcase
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_r <= `IWB_BIT_ZERO;
                     if (!ack_r)
                     begin
                        state_r  <= ST_IGN;
                        sda_oe_o <= 1'b0;
                     end
                     else if (addr_phase_r && rd_mode_r)
                     begin
                        addr_phase_r <= 1'b0;
                        state_r      <= ST_TX;
                        shift_r      <= {read_byte[6:0], 1'b0};
                        sda_oe_o     <= ~read_byte[7];
                     end
                     else
                     begin
                        addr_phase_r <= 1'b0;
                        state_r      <= ST_RX;
                        sda_oe_o     <= 1'b0;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_r <= bit_cnt_r + `IWB_BIT_ONE;
                     if (bit_cnt_r == `IWB_LAST_TX_BIT)
                     begin
                        state_r  <= ST_MACK;
                        sda_oe_o <= 1'b0;
                     end
                     else
                     begin
                        sda_oe_o <= ~shift_r[7];
                        shift_r  <= {shift_r[6:0], 1'b0};
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     ack_r <= ~sda_i;
                  end
                  else if (scl_fall)
                  begin
                     bit_cnt_r <= `IWB_BIT_ZERO;
                     if (ack_r)
                     begin
                        // A fresh sample of the pointed register for each byte.
                        state_r  <= ST_TX;
                        shift_r  <= {read_byte[6:0], 1'b0};
                        sda_oe_o <= ~read_byte[7];
                     end
                     else
                     begin
                        state_r  <= ST_IGN;
                        sda_oe_o <= 1'b0;
                     end
                  end
               end
               ST_IGN:
               begin
                  sda_oe_o <= 1'b0;
               end
               default:
               begin
                  state_r  <= ST_IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wire engine bookkeeping: busy flag and captured results.

   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         wire_busy_flag_o <= 1'b0;
         rx_byte_r        <= `IWB_BYTE_ZERO;
         presence_r       <= 1'b0;
         last_cmd_r       <= `IWB_BYTE_ZERO;
      end
      else
      begin
         if (push_r)
         begin
            last_cmd_r <= push_code_r;
         end
         if (chip_reset_o)
         begin
            wire_busy_flag_o <= 1'b0;
         end
         else
         begin
            // A new command wins over a completion in the same cycle.
            wire_busy_flag_o <= push_r | (wire_busy_flag_o & ~wire_done_i);
         end
         if (wire_done_i && wire_busy_flag_o && !push_r)
         begin
            if (last_cmd_r == `IWB_CMD_BYTE_READ)
            begin
               rx_byte_r <= wire_rx_byte_i;
            end
            if (last_cmd_r == `IWB_CMD_LINE_RESET)
            begin
               presence_r <= wire_presence_i;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command hand-off toward the wire engine.

   iwb_cmd_buffer #(
      .WIDTH (16)
   ) u_cmd_buffer (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_r),
      .in_data_i   ({push_code_r, push_data_r}),
      .in_ready_o  (in_ready),
      .out_valid_o (cmd_valid_o),
      .out_data_o  ({cmd_code_o, cmd_data_o}),
      .out_ready_i (cmd_ready_i)
   );

endmodule // iwb_host_cmd

`default_nettype wire

// >>> iwb_host_cmd_props.sv
// Purpose: Concurrent checks on the ports of the host command interface.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Attached to every instance of the top module by the bind below.
`include "iwb_defines.vh"
`default_nettype none

module iwb_host_cmd_props (
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic       scl_i,
   input wire logic       sda_oe_o,
   input wire logic       cmd_valid_o,
   input wire logic [7:0] cmd_code_o,
   input wire logic [7:0] cmd_data_o,
   input wire logic       cmd_ready_i,
   input wire logic       wire_done_i,
   input wire logic [7:0] line_setup_o,
   input wire logic       chip_reset_o,
   input wire logic       wire_busy_flag_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   // Busy is raised with the acknowledge, the buffer offers the command in the same cycle.
   sequence s_busy_set;
      $rose(wire_busy_flag_o);
   endsequence
   sequence s_push_seen;
      cmd_valid_o;
   endsequence

   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o && !cmd_valid_o
      && !wire_busy_flag_o && line_setup_o == `IWB_SETUP_RESET && !chip_reset_o)
      else $error("outputs not quiet after reset");
   push_follows_a: assert property (s_busy_set |-> s_push_seen)
      else $error("busy set without a command push");
   done_clear_a: assert property (wire_done_i && wire_busy_flag_o |=> !wire_busy_flag_o)
      else $error("busy not cleared after done");
   cmd_hold_a: assert property (cmd_valid_o && !cmd_ready_i |=>
      cmd_valid_o && $stable(cmd_code_o) && $stable(cmd_data_o))
      else $error("pending command changed before taken");
   valid_busy_a: assert property ($rose(cmd_valid_o) |->
      $rose(wire_busy_flag_o))
      else $error("command offered without busy");
   code_legal_a: assert property (cmd_valid_o |-> (cmd_code_o == `IWB_CMD_LINE_RESET
      || cmd_code_o == `IWB_CMD_BYTE_WRITE || cmd_code_o == `IWB_CMD_BYTE_READ)
      && (cmd_code_o == `IWB_CMD_BYTE_WRITE || cmd_data_o == `IWB_BYTE_ZERO))
      else $error("bad command code or data");
   setup_hold_a: assert property (wire_busy_flag_o && $past(wire_busy_flag_o) |->
      $stable(line_setup_o))
      else $error("setup changed while busy");
   reset_pulse_a: assert property (chip_reset_o |=> !chip_reset_o)
      else $error("chip reset longer than one cycle");
   sda_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("sda changed while scl high");
endmodule // iwb_host_cmd_props

bind iwb_host_cmd iwb_host_cmd_props iwb_host_cmd_props_i (.ref_clk_i, .rst_i, .scl_i,
   .sda_oe_o, .cmd_valid_o, .cmd_code_o, .cmd_data_o, .cmd_ready_i, .wire_done_i,
   .line_setup_o, .chip_reset_o, .wire_busy_flag_o);

`default_nettype wire

// >>> iwb_host_master.sv
// Purpose: Host bus master model that drives scl and sda by bit tasks.
// Assumes: The sda line has a pull-up, so a released line reads high.
// Notes:   Every scl half period lasts at least three clocks.
`default_nettype none

module iwb_host_master (
   input  wire logic ref_clk_i,
   input  wire logic sda_line_i,
   output logic      scl_o,
   output logic      sda_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // Start is frame_edge(1, 0); stop is frame_edge(0, 1).
   task automatic frame_edge(input logic first, input logic last);
      @(posedge ref_clk_i);
      scl_o <= 1'b0;
      tick(2);
      sda_o <= first;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= last;
      tick(4);
   endtask

   task automatic bit_out(input logic b);
      @(posedge ref_clk_i);
      scl_o <= 1'b0;
      tick(2);
      sda_o <= b;
      tick(2);
      scl_o <= 1'b1;
      tick(3);
   endtask

   task automatic bit_in(output logic r);
      @(posedge ref_clk_i);
      scl_o <= 1'b0;
      sda_o <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(2);
      r = sda_line_i;
      tick(1);
   endtask

   ////////////////////////////////////////////////////////////
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_out(b[i]);
      bit_in(r);
      ack = !r;
   endtask

   task automatic recv_byte(output logic [7:0] b, input logic ack);
      for (int i = 7; i >= 0; i--)
         bit_in(b[i]);
      bit_out(!ack);
   endtask
endmodule // iwb_host_master

`default_nettype wire

// >>> iwb_host_cmd_tb.sv
// Purpose: Self-checking bench for the host command interface.
// Assumes: A master model drives the bus; a stub engine answers commands.
// Notes:   The stub takes ENG_DELAY clocks per command.
`include "iwb_defines.vh"
`default_nettype none

module iwb_host_cmd_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ENG_DELAY = 400;
   logic            ref_clk_i       = 1'b0;
   logic            rst_i           = 1'b1;
   logic            cmd_ready_i     = 1'b1;
   logic            wire_done_i     = 1'b0;
   logic [7:0]      wire_rx_byte_i  = 8'h00;
   logic            wire_presence_i = 1'b0;
   logic [7:0]      got_code, got_data;
   int              eng_cnt = 0, pulses = 0, fail_count = 0, checks = 0;
   wire logic       scl, msda, sda_i, sda_oe_o, cmd_valid_o, chip_reset_o, wire_busy_flag_o;
   wire logic [7:0] cmd_code_o, cmd_data_o, line_setup_o;
   wire logic       sda_o;

   assign sda_i = msda & ~sda_oe_o;
   always #4 ref_clk_i = ~ref_clk_i;

   iwb_host_cmd iwb_host_cmd_i (.ref_clk_i, .rst_i, .scl_i(scl), .sda_i, .sda_o, .sda_oe_o,
      .cmd_valid_o, .cmd_code_o, .cmd_data_o, .cmd_ready_i, .wire_done_i, .wire_rx_byte_i,
      .wire_presence_i, .line_setup_o, .chip_reset_o, .wire_busy_flag_o);
   iwb_host_master iwb_host_master_i (.ref_clk_i, .sda_line_i(sda_i), .scl_o(scl), .sda_o(msda));

   // Engine stub: takes a command, then reports done after ENG_DELAY clocks.
   always @(posedge ref_clk_i)
   begin
      wire_done_i <= (eng_cnt == 1);
      if (chip_reset_o === 1'b1)
         pulses <= pulses + 1;
      if (eng_cnt != 0)
         eng_cnt <= eng_cnt - 1;
      else if (cmd_valid_o === 1'b1 && cmd_ready_i)
      begin
         got_code <= cmd_code_o;
         got_data <= cmd_data_o;
         eng_cnt  <= ENG_DELAY;
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic xfer(input logic [7:0] b, input logic exp_ack);
      logic a;
      iwb_host_master_i.send_byte(b, a);
      check({7'h00, a}, {7'h00, exp_ack});
   endtask

   task automatic bus_open(input logic rnw);
      iwb_host_master_i.frame_edge(1'b1, 1'b0);
      xfer({`IWB_HOST_ADDR, rnw}, 1'b1);
   endtask

   task automatic halt();
      iwb_host_master_i.frame_edge(1'b0, 1'b1);
   endtask

   task automatic rd(input logic [7:0] exp, input logic more);
      logic [7:0] b;
      iwb_host_master_i.recv_byte(b, more);
      check(b, exp);
   endtask

   task automatic wait_idle();
      for (int n = 0; n < 2000 && wire_busy_flag_o !== 1'b0; n++)
         @(posedge ref_clk_i);
      check({7'h00, wire_busy_flag_o}, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////
   task automatic t_idle();
      bus_open(1'b1);
      rd(`IWB_BYTE_ZERO, 1'b0);
      halt();
      check({7'h00, sda_o}, 8'h00);
      check(line_setup_o, `IWB_SETUP_RESET);
      iwb_host_master_i.frame_edge(1'b1, 1'b0);
      xfer({`IWB_HOST_ADDR ^ 7'h01, 1'b0}, 1'b0);
      halt();
   endtask

   task automatic t_config();
      bus_open(1'b0);
      xfer(`IWB_CMD_CONFIG_WR, 1'b1);
      xfer(8'h5A, 1'b1);
      xfer(`IWB_CMD_LINE_RESET, 1'b0);
      halt();
      check(line_setup_o, 8'h5A);
      bus_open(1'b0);
      xfer(`IWB_CMD_PTR_SELECT, 1'b1);
      xfer(`IWB_PTR_LINE_SETUP, 1'b1);
      bus_open(1'b1);
      rd(8'h5A, 1'b1);
      rd(8'h5A, 1'b0);
      halt();
   endtask

   task automatic t_bad_ptr();
      bus_open(1'b0);
      xfer(8'h3C, 1'b0);
      halt();
      bus_open(1'b0);
      xfer(`IWB_CMD_PTR_SELECT, 1'b1);
      xfer(8'hE5, 1'b0);
      bus_open(1'b1);
      rd(8'h5A, 1'b0);
      halt();
   endtask

   task automatic t_write_busy();
      logic [7:0] refused [4] = '{`IWB_CMD_CONFIG_WR, `IWB_CMD_LINE_RESET,
                                  `IWB_CMD_BYTE_WRITE, `IWB_CMD_BYTE_READ};
      logic [7:0] b = 8'h01;
      cmd_ready_i <= 1'b0;
      bus_open(1'b0);
      xfer(`IWB_CMD_BYTE_WRITE, 1'b1);
      xfer(8'h33, 1'b1);
      xfer(8'h44, 1'b0);
      halt();
      check({7'h00, wire_busy_flag_o}, 8'h01);
      check(cmd_code_o, `IWB_CMD_BYTE_WRITE);
      check(cmd_data_o, 8'h33);
      foreach (refused[i])
      begin
         bus_open(1'b0);
         xfer(refused[i], 1'b0);
         halt();
      end
      check(line_setup_o, 8'h5A);
      bus_open(1'b0);
      xfer(`IWB_CMD_PTR_SELECT, 1'b1);
      xfer(`IWB_PTR_STATUS, 1'b1);
      bus_open(1'b1);
      rd(8'h01, 1'b1);
      cmd_ready_i <= 1'b1;
      for (int n = 0; n < 30 && b === 8'h01; n++)
         iwb_host_master_i.recv_byte(b, 1'b1);
      check(b, 8'h00);
      rd(8'h00, 1'b0);
      halt();
      check(got_code, `IWB_CMD_BYTE_WRITE);
      check(got_data, 8'h33);
   endtask

   task automatic t_line_reset();
      wire_presence_i <= 1'b1;
      bus_open(1'b0);
      xfer(`IWB_CMD_LINE_RESET, 1'b1);
      halt();
      wait_idle();
      check(got_code, `IWB_CMD_LINE_RESET);
      bus_open(1'b1);
      rd(8'h02, 1'b0);
      halt();
   endtask

   task automatic t_read_byte();
      wire_rx_byte_i <= 8'hC6;
      bus_open(1'b0);
      xfer(`IWB_CMD_BYTE_READ, 1'b1);
      bus_open(1'b0);
      xfer(`IWB_CMD_PTR_SELECT, 1'b1);
      xfer(`IWB_PTR_RX_BYTE, 1'b1);
      halt();
      check({7'h00, wire_busy_flag_o}, 8'h01);
      wait_idle();
      bus_open(1'b1);
      rd(8'hC6, 1'b1);
      rd(8'hC6, 1'b0);
      halt();
      check(got_data, `IWB_BYTE_ZERO);
   endtask

   task automatic t_chip_reset();
      logic [7:0] b;
      bus_open(1'b0);
      xfer(`IWB_CMD_CHIP_RESET, 1'b1);
      halt();
      check(pulses[7:0], 8'h01);
      check(line_setup_o, `IWB_SETUP_RESET);
      bus_open(1'b1);
      iwb_host_master_i.recv_byte(b, 1'b0);
      check(b & 8'hFD, `IWB_BYTE_ZERO);
      halt();
   endtask

   initial
   begin
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      t_idle();
      t_config();
      t_bad_ptr();
      t_write_busy();
      t_line_reset();
      t_read_byte();
      t_chip_reset();
      conclude();
   end

   initial
   begin
      repeat (30000) @(posedge ref_clk_i);
      fail_count++;
      conclude();
   end
endmodule // iwb_host_cmd_tb

`default_nettype wire
